// file: hdl/axs7_regs.vh
/*
  Register offsets, field positions, reset value and decode codes for the
  step-seven configuration register of the auxiliary converter sequencer.
  Assumes inclusion by the design files only.
*/
`ifndef AXS7_REGS_VH
`define AXS7_REGS_VH

// ****************************************
// Register map
// ****************************************
`define AXS7_IDX_STEP7_CFG 8'h97
`define AXS7_ADDR_STEP7_CFG 12'h25c
`define AXS7_RST_STEP7_CFG 16'h0007
`define AXS7_WR_MASK 16'he01f

// ****************************************
// Field positions
// ****************************************
`define AXS7_EN_BIT 15
`define AXS7_GAIN_HI 14
`define AXS7_GAIN_LO 13
`define AXS7_NEG_BIT 4
`define AXS7_POS_HI 3
`define AXS7_POS_LO 0

// ****************************************
// Decode codes
// ****************************************
`define AXS7_GAIN_X1 2'h0
`define AXS7_GAIN_X2 2'h1
`define AXS7_GAIN_X4 2'h2
`define AXS7_SRC_EXT 3'h0
`define AXS7_SRC_TEMP 3'h1
`define AXS7_SRC_SHORT 3'h2
`define AXS7_SRC_TDAC 3'h3
`define AXS7_SRC_SUP4 3'h4
`define AXS7_SRC_RAIL103 3'h5
`define AXS7_POS_TEMP 4'h8
`define AXS7_POS_SHORT 4'h9
`define AXS7_POS_TDAC 4'ha
`define AXS7_POS_AVDD4 4'hb
`define AXS7_POS_IOVDD4 4'hc
`define AXS7_POS_DVDD4 4'hd
`define AXS7_POS_ANALOG_POWER_RAIL 4'he
`define AXS7_POS_DIGITAL_POWER_RAIL 4'hf

`endif

// file: hdl/axs7_route.v
/*
  Combinational decode of the step-seven fields into gain and input routing.
  Assumes its inputs come from registers on the same clock.
*/
`include "axs7_regs.vh"
`default_nettype none

module axs7_route (
  input wire [1:0] gain_sel, // Gain field
  input wire neg_sel, // Negative select bit
  input wire [3:0] pos_sel, // Positive selector
  output reg [1:0] gain_code, // Decoded gain
  output reg [2:0] src_kind, // Positive source class
  output reg [7:0] ext_onehot, // External input one-hot
  output reg [1:0] supply_pick, // Which supply or rail
  output reg neg_auto, // Negative input chosen internally
  output reg neg_ext7 // Negative on external input seven
);

  // ****************************************
  // Field decode
  // ****************************************
  // Gain: 10 and 11 both mean x4
  always @* begin
    case (gain_sel)
      2'h0: gain_code = `AXS7_GAIN_X1;
      2'h1: gain_code = `AXS7_GAIN_X2;
      default: gain_code = `AXS7_GAIN_X4;
    endcase
  end

  // Positive selector and negative override
  always @* begin
    ext_onehot = 8'h00;
    supply_pick = 2'h0;
    neg_auto = pos_sel[3];
    case (pos_sel)
      `AXS7_POS_TEMP: src_kind = `AXS7_SRC_TEMP;
      `AXS7_POS_SHORT: src_kind = `AXS7_SRC_SHORT;
      `AXS7_POS_TDAC: src_kind = `AXS7_SRC_TDAC;
      `AXS7_POS_AVDD4: src_kind = `AXS7_SRC_SUP4;
      `AXS7_POS_IOVDD4: begin
        src_kind = `AXS7_SRC_SUP4;
        supply_pick = 2'h1;
      end
      `AXS7_POS_DVDD4: begin
        src_kind = `AXS7_SRC_SUP4;
        supply_pick = 2'h2;
      end
      `AXS7_POS_ANALOG_POWER_RAIL: src_kind = `AXS7_SRC_RAIL103;
      `AXS7_POS_DIGITAL_POWER_RAIL: begin
        src_kind = `AXS7_SRC_RAIL103;
        supply_pick = 2'h1;
      end
      default: begin
        src_kind = `AXS7_SRC_EXT;
        ext_onehot = 8'h01 << pos_sel[2:0];
      end
    endcase
    // Bit ignored whenever an internal source is picked
    neg_ext7 = neg_sel & ~pos_sel[3];
  end

endmodule // axs7_route

`default_nettype wire

// file: hdl/axs7_step7_cfg.v
/*
  Step-seven configuration register of the auxiliary converter sequencer,
  with APB slave access and the routing handed to the converter.
  Assumes a sequencer on ref_clk that pulses step_seven_active per conversion.
*/
// What this block does
// - Bit 15 enables sequence step seven
// - Gain bits 14:13 give 1, 2, 4, 4
// - Bit 4 picks ground or input seven
// - Codes 0-7 route external inputs in order
// - Codes 8-10: temperature, short, test DAC
// - Codes 11-15 select scaled supply monitors
// - Internal source picks negative input automatically
// - Address 97h, reset value 0007h
`include "axs7_regs.vh"
`default_nettype none

module axs7_step7_cfg (
  input wire ref_clk, // 10 MHz clock
  input wire rst_n, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire step_seven_active, // Sequencer at step seven
  output reg step_seven_enable, // Step included in sequence
  output reg conv_valid, // Routing valid for conversion
  output reg [1:0] conv_gain, // Applied gain code
  output reg [2:0] conv_src_kind, // Applied source class
  output reg [7:0] conv_ext_onehot, // Applied external input
  output reg [1:0] conv_supply_pick, // Applied supply choice
  output reg conv_neg_auto, // Negative internally chosen
  output reg conv_neg_ext7 // Negative on input seven
);

  // ****************************************
  // Constants
  // ****************************************
  // Stored bits of the word; the reserved span 12:5 never holds a one
  localparam [15:0] WR_MASK = `AXS7_WR_MASK;
  localparam [15:0] RST_VAL = `AXS7_RST_STEP7_CFG;
  localparam [11:0] CFG_ADDR = `AXS7_ADDR_STEP7_CFG;
  localparam integer LANES = 2;

  // ****************************************
  // Declarations
  // ****************************************
  reg [15:0] cfg_q;
  wire [15:0] cfg_d;
  wire [LANES-1:0] lane_en;
  wire en_f;
  wire [1:0] gain_f;
  wire neg_f;
  wire [3:0] pos_f;
  wire [1:0] gain_code;
  wire [2:0] src_kind;
  wire [7:0] ext_onehot;
  wire [1:0] supply_pick;
  wire neg_auto;
  wire neg_ext7;
  wire setup_hit;
  wire access_hit;
  wire write_hit;
  wire read_hit;
  wire miss_hit;
  wire step_go;

  // ****************************************
  // Bus decode
  // ****************************************
  // One mapped word; any other offset is answered with an error
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a == CFG_ADDR);
    end
  endfunction

  // Read view: reserved span and upper half always come back as zero
  function [31:0] read_word;
    input [15:0] r;
    begin
      read_word = {16'h0000, r & WR_MASK};
    end
  endfunction

  // Setup-phase detection: answer the cycle after setup
  assign setup_hit = psel & ~penable;
  assign access_hit = psel & penable & pready;
  // Writes commit at the access edge; reads are fetched at setup
  assign write_hit = access_hit & pwrite & addr_hit(paddr);
  assign read_hit = setup_hit & ~pwrite & addr_hit(paddr);
  assign miss_hit = setup_hit & ~addr_hit(paddr);

  // ****************************************
  // Byte-lane write
  // ****************************************
  // Each lane stores only under its own strobe; upper strobes have no lane
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign lane_en[g] = write_hit & pstrb[g];
      assign cfg_d[8*g+7:8*g] = lane_en[g] ?
        (pwdata[8*g+7:8*g] & WR_MASK[8*g+7:8*g]) : cfg_q[8*g+7:8*g];
    end
  endgenerate

  // ****************************************
  // Register storage
  // ****************************************
  // Stored word; only the access edge of a hit write changes it
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= RST_VAL;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Ready one cycle after setup: every access lasts exactly one cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_hit;
    end
  end

  // Error pulse beside ready for any offset outside the map
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= miss_hit;
    end
  end

  // Read data stands only in the ready cycle of a read hit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= read_hit ? read_word(cfg_q) : 32'h0000_0000;
    end
  end

  // ****************************************
  // Routing decode
  // ****************************************
  // Field views of the stored word
  assign en_f = cfg_q[`AXS7_EN_BIT];
  assign gain_f = cfg_q[`AXS7_GAIN_HI:`AXS7_GAIN_LO];
  assign neg_f = cfg_q[`AXS7_NEG_BIT];
  assign pos_f = cfg_q[`AXS7_POS_HI:`AXS7_POS_LO];
  assign step_go = step_seven_active & en_f;

  axs7_route u_route (
    .gain_sel(gain_f),
    .neg_sel(neg_f),
    .pos_sel(pos_f),
    .gain_code(gain_code),
    .src_kind(src_kind),
    .ext_onehot(ext_onehot),
    .supply_pick(supply_pick),
    .neg_auto(neg_auto),
    .neg_ext7(neg_ext7)
  );

  // ****************************************
  // Conversion hand-off
  // ****************************************
  // Enable copy trails the register by one cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_seven_enable <= 1'b0;
    end else begin
      step_seven_enable <= en_f;
    end
  end

  // Valid pulse marks the cycle that carries fresh routing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_valid <= 1'b0;
    end else begin
      conv_valid <= step_go;
    end
  end

  // Latch routing only when the step runs, so a write mid-conversion
  // cannot disturb the settled front end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_gain <= `AXS7_GAIN_X1;
      conv_src_kind <= `AXS7_SRC_EXT;
      conv_ext_onehot <= 8'h00;
      conv_supply_pick <= 2'h0;
      conv_neg_auto <= 1'b0;
      conv_neg_ext7 <= 1'b0;
    end else if (step_go) begin
      conv_gain <= gain_code;
      conv_src_kind <= src_kind;
      conv_ext_onehot <= ext_onehot;
      conv_supply_pick <= supply_pick;
      conv_neg_auto <= neg_auto;
      conv_neg_ext7 <= neg_ext7;
    end
  end

endmodule // axs7_step7_cfg

`default_nettype wire

// file: testbench/axs7_chk.sv
/* Port assertions for the step-seven config register.
   Assumes a bind onto axs7_step7_cfg, one clock domain. */
`default_nettype none
// ****
// Checker
// ****
module axs7_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic step_seven_active, // Step strobe
  input wire logic step_seven_enable, // Enable copy
  input wire logic conv_valid, // Applied
  input wire logic [1:0] conv_gain, // Gain
  input wire logic [2:0] conv_src_kind, // Source
  input wire logic [7:0] conv_ext_onehot, // External input
  input wire logic conv_neg_auto, // Auto negative
  input wire logic conv_neg_ext7 // Negative on seven
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Bus phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr15; psel && penable && pready && pwrite && paddr == 12'h25c && pstrb[1]
    && pwdata[15]; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; s_setup ##0 paddr != 12'h25c |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rsv; pready |-> prdata[31:16] == 16'h0 && prdata[12:5] == 8'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
  property p_en; s_wr15 |-> ##[1:2] step_seven_enable; endproperty
  a_en: assert property (p_en) else $error("enable not seen");
  // Applied routing, one cycle late so the decode is stable
  property p_val; conv_valid |-> $past(step_seven_active); endproperty
  a_val: assert property (p_val) else $error("valid without step");
  property p_gain; conv_valid |-> conv_gain != 2'h3; endproperty
  a_gain: assert property (p_gain) else $error("bad gain code");
  property p_ext; conv_valid && conv_src_kind == 3'h0 |-> $onehot(conv_ext_onehot)
    && !conv_neg_auto; endproperty
  a_ext: assert property (p_ext) else $error("external route wrong");
  property p_auto; conv_valid && conv_src_kind != 3'h0 |-> conv_neg_auto && !conv_neg_ext7
    && conv_ext_onehot == 8'h0; endproperty
  a_auto: assert property (p_auto) else $error("internal route wrong");
endmodule // axs7_chk
bind axs7_step7_cfg axs7_chk u_chk (.*);
`default_nettype wire

// file: testbench/testbench.sv
/* Bench for the step-seven config register over APB.
   Assumes design and checker compiled first. */
`default_nettype none
// ****
// Bench
// ****
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] cfg_addr = 12'h25c;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, act = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, er, en, cv, na, n7;
  logic [1:0] cg, sp;
  logic [2:0] sk;
  logic [7:0] oh;
  int num_errors = 0, n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  axs7_step7_cfg dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_seven_active(act), .step_seven_enable(en),
    .conv_valid(cv), .conv_gain(cg), .conv_src_kind(sk), .conv_ext_onehot(oh),
    .conv_supply_pick(sp), .conv_neg_auto(na), .conv_neg_ext7(n7));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer; holds until ready so a slow slave also works
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sequencer reaches step seven for one cycle
  task fire;
    @(posedge ref_clk);
    act <= 1'b1;
    @(posedge ref_clk);
    act <= 1'b0;
    #1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300000;
    num_errors++;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, cfg_addr, 32'h0, 4'h0);
    chk(rd, 32'h7);
    apb(1'b1, cfg_addr, 32'hffffffff, 4'hf);
    apb(1'b0, cfg_addr, 32'h0, 4'h0);
    chk(rd, 32'he01f);
    apb(1'b1, 12'h258, 32'h0, 4'hf);
    chk(er, 1'b1);
    apb(1'b0, 12'h258, 32'h0, 4'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, cfg_addr, 32'h0, 4'h1);
    apb(1'b0, cfg_addr, 32'h0, 4'h0);
    chk(rd, 32'he000);
    apb(1'b1, cfg_addr, 32'h0, 4'h3);
    fire;
    chk({en, cv}, 2'b00);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, cfg_addr, {16'h0, 1'b1, 2'(c), 8'h0, c[0], 4'(c)}, 4'h3);
      fire;
      chk({en, cv}, 2'b11);
      chk(cg, c[1:0] == 2'h3 ? 2'h2 : c[1:0]);
      chk(sk, c < 8 ? 0 : c < 11 ? c - 7 : c < 14 ? 4 : 5);
      chk(oh, c < 8 ? 1 << c : 0);
      if (c > 10)
        chk(sp, c < 14 ? c - 11 : c - 14);
      chk({na, n7}, {c > 7, c < 8 && c[0]});
    end
    // A write with no step leaves the applied routing untouched
    apb(1'b1, cfg_addr, 32'h0000_8000, 4'h3);
    @(negedge ref_clk);
    chk({cv, cg, sk}, {1'b0, 2'h2, 3'h5});
    fire;
    chk({cv, cg, sk, oh}, {1'b1, 2'h0, 3'h0, 8'h01});
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
